// [core/ioe_pkg.sv]
// Shared constants, field positions and carrier types of the port expander core
package ioe_pkg;
  // Register command addresses
  localparam logic [7:0] ADR_INPUT = 8'h00;
  localparam logic [7:0] ADR_PH0 = 8'h01;
  localparam logic [7:0] ADR_DIR = 8'h03;
  localparam logic [7:0] ADR_PH1 = 8'h09;
  localparam logic [7:0] ADR_MASTER = 8'h0E;
  localparam logic [7:0] ADR_SETUP = 8'h0F;
  localparam logic [7:0] ADR_INT0 = 8'h10;
  localparam logic [7:0] ADR_INT3 = 8'h13;
  localparam logic [7:0] INT_GROUP_MASK = 8'hFC;
  // Power-up values
  localparam logic [7:0] RST_PH0 = 8'hFF;
  localparam logic [7:0] RST_DIR = 8'hFF;
  localparam logic [7:0] RST_PH1 = 8'hFF;
  localparam logic [7:0] RST_MASTER = 8'h0F;
  localparam logic [5:0] RST_SETUP = 6'h0C;
  localparam logic [7:0] RST_INT = 8'hFF;
  localparam logic [7:0] RST_PTR = 8'h00;
  // Setup register bit positions
  localparam int CFG_BLINK = 0;
  localparam int CFG_FLIP = 1;
  localparam int CFG_GLOBAL = 2;
  localparam int CFG_IRQEN = 3;
  localparam int CFG_LVL0 = 4;
  localparam int CFG_LVL1 = 5;
  localparam int CFG_ZERO = 6;
  localparam int CFG_FLAG = 7;
  // Timing counts
  localparam logic [1:0] INIT_SNAP = 2'h2;
  localparam logic [1:0] INIT_DONE = 2'h3;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int SYNC_W = 17;

  // Byte received from the serial link
  typedef struct packed {
    logic valid;
    logic first;
    logic [7:0] data;
  } ioe_rx_s;

  // Read data requests from the serial link
  typedef struct packed {
    logic load;
    logic next;
  } ioe_tx_s;

  // Serial slave states, Gray coded along the usual path
  typedef enum logic [2:0] {
    LK_IDLE = 3'h0,
    LK_ADDR = 3'h1,
    LK_ACKA = 3'h3,
    LK_RX = 3'h2,
    LK_ACKW = 3'h6,
    LK_TX = 3'h7,
    LK_ACKR = 3'h5
  } ioe_link_e;
endpackage

// [core/ioe_sync.sv]
// Two-flop synchroniser for pins and the serial link lines
`timescale 1ns/1ps
module ioe_sync import ioe_pkg::*; #(
  parameter int W = SYNC_W
) (
  input wire logic sys_clk, // System clock
  input wire logic arst_n, // Asynchronous reset
  input wire logic [W-1:0] d, // Asynchronous inputs
  output logic [W-1:0] q // Synchronised outputs
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ioe_sync_s;

  ioe_sync_s r;
  ioe_sync_s n;

  // First stage feeds only the second stage
  always_comb begin
    n.s1 = d;
    n.s2 = r.s1;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q = r.s2;
endmodule

// [core/ioe_i2c_link.sv]
// Two-wire serial slave: framing, address match, acknowledge and byte strobes
`timescale 1ns/1ps
module ioe_i2c_link import ioe_pkg::*; (
  input wire logic sys_clk, // System clock
  input wire logic arst_n, // Asynchronous reset
  input wire logic sclS, // Synchronised serial clock
  input wire logic sdaS, // Synchronised serial data
  input wire logic [6:0] devAddr, // Own slave address
  input wire logic [7:0] txData, // Next byte to send
  output ioe_rx_s rx, // Received byte strobe
  output ioe_tx_s txReq, // Read data requests
  output logic stopEv, // Stop seen
  output logic sdaOe // Pull data line low
);
  typedef struct packed {
    ioe_link_e st;
    logic sclP;
    logic sdaP;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic first;
    logic ack;
    logic oe;
    ioe_rx_s rx;
    ioe_tx_s tx;
    logic stop;
  } ioe_lnk_s;

  ioe_lnk_s r;
  ioe_lnk_s n;
  logic rise;
  logic fall;
  logic startC;
  logic stopC;

  // Edges are found by the system clock on the sampled lines
  assign rise = sclS & ~r.sclP;
  assign fall = ~sclS & r.sclP;
  assign startC = sclS & r.sclP & r.sdaP & ~sdaS;
  assign stopC = sclS & r.sclP & ~r.sdaP & sdaS;

  // Slave sequence; a start anywhere restarts address reception
  always_comb begin
    n = r;
    n.sclP = sclS;
    n.sdaP = sdaS;
    n.rx.valid = 1'b0;
    n.tx = '0;
    n.stop = 1'b0;
    if (startC) begin
      n.st = LK_ADDR;
      n.cnt = '0;
      n.oe = 1'b0;
      n.first = 1'b1;
    end else if (stopC) begin
      n.st = LK_IDLE;
      n.oe = 1'b0;
      n.stop = 1'b1;
    end else begin
      case (r.st)
        LK_IDLE: begin
          n.oe = 1'b0;
        end
        LK_ADDR, LK_RX: begin
          if (rise) begin
            n.sh = {r.sh[6:0], sdaS};
            n.cnt = 4'(r.cnt + 4'h1);
          end else if (fall && r.cnt == BYTE_BITS) begin
            n.oe = 1'b1;
            if (r.st == LK_RX) begin
              n.rx.valid = 1'b1;
              n.rx.first = r.first;
              n.rx.data = r.sh;
              n.first = 1'b0;
              n.st = LK_ACKW;
            end else if (r.sh[7:1] == devAddr) begin
              n.rw = r.sh[0];
              n.tx.load = r.sh[0];
              n.st = LK_ACKA;
            end else begin
              n.oe = 1'b0;
              n.st = LK_IDLE;
            end
          end
        end
        LK_ACKA, LK_ACKW: begin
          if (fall) begin
            n.cnt = '0;
            if (r.st == LK_ACKA && r.rw) begin
              n.sh = txData;
              n.oe = ~txData[7];
              n.st = LK_TX;
            end else begin
              n.oe = 1'b0;
              n.st = LK_RX;
            end
          end
        end
        LK_TX: begin
          if (rise) begin
            n.cnt = 4'(r.cnt + 4'h1);
          end else if (fall) begin
            if (r.cnt == BYTE_BITS) begin
              n.oe = 1'b0;
              n.st = LK_ACKR;
            end else begin
              n.sh = {r.sh[6:0], 1'b0};
              n.oe = ~r.sh[6];
            end
          end
        end
        LK_ACKR: begin
          if (rise) begin
            n.ack = ~sdaS;
            n.tx.next = 1'b1;
          end else if (fall) begin
            n.cnt = '0;
            if (r.ack) begin
              n.sh = txData;
              n.oe = ~txData[7];
              n.st = LK_TX;
            end else begin
              n.st = LK_IDLE;
            end
          end
        end
        default: begin
          n.st = LK_IDLE;
          n.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{st: LK_IDLE, sclP: 1'b1, sdaP: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  assign rx = r.rx;
  assign txReq = r.tx;
  assign stopEv = r.stop;
  assign sdaOe = r.oe;
endmodule

// [core/ioe_port_core.sv]
// Register core of the eight-port expander with change detection and shared ninth pin
// Notes on behaviour
// - First data byte of a write goes to the commanded register, later ones auto-incremented.
// - Pointer holds at 00,01,03,09,0E,0F; cycles 10 to 13 then back to 10.
// - Reads start at the stored pointer and advance it after every byte read.
// - Stop right after the command byte only updates the pointer.
// - Power-up values: ones in 01,03,09,10-13; 0E is 0F; setup is 0C.
// - Direction bit one makes a port an input, zero an output.
// - Address 00 returns live pin levels of all ports; writes there are dropped.
// - Reading address 00 or writing setup captures the port snapshot.
// - Any input port differing from its snapshot raises the change condition.
// - The condition clears when inputs return or the snapshot is refreshed.
// - Snapshot is taken right after reset so valid pins raise no change.
// - Setup D3 set makes the ninth pin the change output, else a general output.
// - Setup D7 reads the change flag, D6 reads zero; change output pulls low.
// - As general output the ninth pin follows D4, or D5 in blink phase one.
// - D0 enables blink; then D1 picks phase one register, else phase zero.
// - D2 set gives all ports the low nibble of 0E, else per-port nibbles.
// - The ninth pin takes its intensity from the low nibble of 0E.
`timescale 1ns/1ps
module ioe_port_core import ioe_pkg::*; (
  input wire logic sys_clk, // System clock, 20 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic sclIn, // Serial clock pin
  input wire logic sdaIn, // Serial data pin level
  output logic sdaOut, // Serial data drive value
  output logic sdaOe, // Serial data pull-low enable
  input wire logic [6:0] devAddr, // Slave address straps
  input wire logic [7:0] portIn, // Port pin levels
  output logic [7:0] portOut, // Port drive values
  output logic [7:0] portOe, // Port pull-low enables
  output logic ninthOut, // Ninth pin drive value
  output logic ninthOe, // Ninth pin pull-low enable
  output logic [7:0][3:0] portIntensity, // Per-port PWM setting
  output logic [3:0] ninthIntensity, // Ninth pin PWM setting
  output logic [3:0] masterIntensity // Master PWM gate setting
);
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] ph0;
    logic [7:0] dir;
    logic [7:0] ph1;
    logic [7:0] master;
    logic [5:0] setup;
    logic [3:0][7:0] intens;
    logic [7:0] snap;
    logic [7:0] txData;
    logic [1:0] initCnt;
    logic [7:0] portOe;
    logic ninthOe;
    logic [7:0][3:0] portInt;
    logic [3:0] ninthInt;
  } ioe_core_s;

  localparam ioe_core_s CORE_RST = '{
    ptr: RST_PTR, ph0: RST_PH0, dir: RST_DIR, ph1: RST_PH1, master: RST_MASTER,
    setup: RST_SETUP, intens: {4{RST_INT}}, default: '0};

  ioe_core_s r;
  ioe_core_s n;
  logic [SYNC_W-1:0] syncQ;
  logic [7:0] pinS;
  logic [6:0] addrS;
  logic sclS;
  logic sdaS;
  ioe_rx_s rx;
  ioe_tx_s txReq;
  logic changed;
  logic phaseOne;
  logic gpoLevel;
  logic [7:0] outSel;
  logic [7:0] portLow;
  logic [7:0][3:0] portNib;

  // Every outside level passes two flops before use
  ioe_sync #(.W(SYNC_W)) u_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .d({devAddr, portIn, ~sdaIn, ~sclIn}),
    .q(syncQ)
  );
  // Link lines pass inverted, so cleared flops read as a released bus and no false edge follows reset
  assign {addrS, pinS} = syncQ[SYNC_W-1:2];
  assign sdaS = ~syncQ[1];
  assign sclS = ~syncQ[0];

  ioe_i2c_link u_link (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .sclS(sclS),
    .sdaS(sdaS),
    .devAddr(addrS),
    .txData(r.txData),
    .rx(rx),
    .txReq(txReq),
    .stopEv(),
    .sdaOe(sdaOe)
  );

  // Address holds a register
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ADR_INPUT) || (a == ADR_PH0) || (a == ADR_DIR) || (a == ADR_PH1) ||
             (a == ADR_MASTER) || (a == ADR_SETUP) || ((a & INT_GROUP_MASK) == ADR_INT0);
  endfunction

  // Only the intensity group advances; everything else holds
  function automatic logic [7:0] nextPtr(input logic [7:0] a);
    if ((a & INT_GROUP_MASK) == ADR_INT0) begin
      nextPtr = {ADR_INT0[7:2], 2'(a[1:0] + 2'h1)};
    end else begin
      nextPtr = a;
    end
  endfunction

  // Read mux; unmapped addresses give zero
  function automatic logic [7:0] rdVal(input logic [7:0] a, input ioe_core_s s,
                                       input logic [7:0] pins, input logic chg);
    rdVal = 8'h00;
    if (a == ADR_INPUT) begin
      rdVal = pins;
    end else if (a == ADR_PH0) begin
      rdVal = s.ph0;
    end else if (a == ADR_DIR) begin
      rdVal = s.dir;
    end else if (a == ADR_PH1) begin
      rdVal = s.ph1;
    end else if (a == ADR_MASTER) begin
      rdVal = s.master;
    end else if (a == ADR_SETUP) begin
      rdVal = {chg, 1'b0, s.setup};
    end else if ((a & INT_GROUP_MASK) == ADR_INT0) begin
      rdVal = s.intens[a[1:0]];
    end
  endfunction

  // Change detection on input-configured ports only
  // Held off until the power-up snapshot exists, since the pin flops clear to zero
  assign changed = (r.initCnt == INIT_DONE) && (|((pinS ^ r.snap) & r.dir));

  // Blink phase selection for ports and the ninth pin
  assign phaseOne = r.setup[CFG_BLINK] & r.setup[CFG_FLIP];
  assign outSel = phaseOne ? r.ph1 : r.ph0;
  assign gpoLevel = phaseOne ? r.setup[CFG_LVL1] : r.setup[CFG_LVL0];

  // Per-port drive and intensity source
  for (genvar gi = 0; gi < 8; gi++) begin : g_port
    assign portLow[gi] = ~r.dir[gi] & ~outSel[gi];
    assign portNib[gi] = r.setup[CFG_GLOBAL] ? r.master[3:0] :
                         r.intens[gi / 2][(gi % 2) * 4 +: 4];
  end

  // Register writes, pointer handling, snapshot and pin drive
  always_comb begin
    n = r;
    if (r.initCnt != INIT_DONE) begin
      n.initCnt = 2'(r.initCnt + 2'h1);
      if (r.initCnt == INIT_SNAP) begin
        n.snap = pinS;
      end
    end
    if (rx.valid) begin
      if (rx.first) begin
        n.ptr = rx.data;
      end else if (mapped(r.ptr)) begin
        n.ptr = nextPtr(r.ptr);
        if (r.ptr == ADR_PH0) begin
          n.ph0 = rx.data;
        end else if (r.ptr == ADR_DIR) begin
          n.dir = rx.data;
        end else if (r.ptr == ADR_PH1) begin
          n.ph1 = rx.data;
        end else if (r.ptr == ADR_MASTER) begin
          n.master = rx.data;
        end else if (r.ptr == ADR_SETUP) begin
          n.setup = rx.data[5:0];
          n.snap = pinS;
        end else if (r.ptr != ADR_INPUT) begin
          n.intens[r.ptr[1:0]] = rx.data;
        end
      end
    end
    // Read data is prefetched so the link has it before the next falling edge
    if (txReq.load) begin
      n.txData = rdVal(r.ptr, r, pinS, changed);
      if (r.ptr == ADR_INPUT) begin
        n.snap = pinS;
      end
    end else if (txReq.next) begin
      n.ptr = nextPtr(r.ptr);
      n.txData = rdVal(nextPtr(r.ptr), r, pinS, changed);
      if (nextPtr(r.ptr) == ADR_INPUT) begin
        n.snap = pinS;
      end
    end
    n.portOe = portLow;
    n.ninthOe = r.setup[CFG_IRQEN] ? changed : ~gpoLevel;
    n.portInt = portNib;
    n.ninthInt = r.master[3:0];
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= CORE_RST;
    end else begin
      r <= n;
    end
  end

  // Open-drain pins only ever pull low
  assign sdaOut = 1'b0;
  assign portOut = 8'h00;
  assign ninthOut = 1'b0;
  assign portOe = r.portOe;
  assign ninthOe = r.ninthOe;
  assign portIntensity = r.portInt;
  assign ninthIntensity = r.ninthInt;
  assign masterIntensity = r.master[7:4];

  // Checks on pointer, registers and pins
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  a_ptr_cmd_load: assert property (
    rx.valid && rx.first |=> r.ptr == $past(rx.data))
    else $error("command byte not stored as pointer");
  a_ptr_wrap: assert property (
    rx.valid && !rx.first && r.ptr == ADR_INT3 |=> r.ptr == ADR_INT0 && r.intens[3] == $past(rx.data))
    else $error("intensity pointer did not wrap");
  a_ptr_fixed_hold: assert property (
    (rx.valid && !rx.first || txReq.next) && (r.ptr == ADR_PH0 || r.ptr == ADR_SETUP) |=> $stable(r.ptr))
    else $error("fixed pointer moved");
  a_read_advance: assert property (
    txReq.next && r.ptr == ADR_INT0 |=> r.ptr == 8'h11 ##0 r.txData == r.intens[1])
    else $error("read did not advance pointer");
  a_input_ro: assert property (
    rx.valid && !rx.first && r.ptr == ADR_INPUT |=> $stable(r.ph0) && $stable(r.dir) && $stable(r.setup))
    else $error("write to input register changed state");
  a_snap_on_read: assert property (
    txReq.load && r.ptr == ADR_INPUT |=> r.snap == $past(pinS) && r.txData == $past(pinS))
    else $error("input read did not refresh snapshot");
  a_init_snap: assert property (
    r.initCnt == INIT_SNAP |=> r.snap == $past(pinS) ##1 r.initCnt == INIT_DONE)
    else $error("snapshot not taken after reset");
  a_irq_pin_low: assert property (
    r.setup[CFG_IRQEN] && changed |=> ninthOe)
    else $error("change output not pulled low");
  a_flag_readback: assert property (
    txReq.load && r.ptr == ADR_SETUP |=> r.txData[CFG_ZERO] == 1'b0 && r.txData[CFG_FLAG] == $past(changed))
    else $error("setup readback flag wrong");
  a_gpo_level: assert property (
    !r.setup[CFG_IRQEN] && !r.setup[CFG_BLINK] |=> ninthOe == !$past(r.setup[CFG_LVL0]))
    else $error("general output level wrong");
  a_dir_gate: assert property (
    1'b1 |=> (portOe & $past(r.dir)) == 8'h00)
    else $error("input port driven");
  a_global_int: assert property (
    r.setup[CFG_GLOBAL] |=> portIntensity[5] == $past(r.master[3:0]))
    else $error("global intensity not applied");
  a_unmapped_hold: assert property (
    rx.valid && !rx.first && !mapped(r.ptr) |=> $stable(r.ptr) && $stable(r.intens) && $stable(r.master))
    else $error("unmapped write had an effect");

  // Command-only frames, unmapped reads, setup snapshot and the power-up quiet time
  a_cmd_no_write: assert property (
    rx.valid && rx.first |=> $stable({r.ph0, r.dir, r.ph1, r.master, r.setup, r.intens}))
    else $error("command byte changed a register");
  a_unmapped_read: assert property (
    txReq.next && !mapped(r.ptr) |=> $stable(r.ptr) && r.txData == 8'h00)
    else $error("unmapped read not zero or pointer moved");
  a_setup_snap: assert property (
    rx.valid && !rx.first && r.ptr == ADR_SETUP |=> r.snap == $past(pinS))
    else $error("setup write did not refresh snapshot");
  a_init_quiet: assert property (
    r.initCnt != INIT_DONE |=> !ninthOe)
    else $error("change output raised during power-up");
  // Change condition, pin drive and intensity sources
  a_change_live: assert property (
    r.initCnt == INIT_DONE |-> changed == ((pinS & r.dir) != (r.snap & r.dir)))
    else $error("change condition does not track inputs");
  a_phase_zero: assert property (
    !r.setup[CFG_BLINK] |=> portOe == (~$past(r.dir) & ~$past(r.ph0)))
    else $error("phase zero outputs not applied");
  a_phase_one: assert property (
    r.setup[CFG_BLINK] && r.setup[CFG_FLIP] |=> portOe == (~$past(r.dir) & ~$past(r.ph1)))
    else $error("phase one outputs not applied");
  a_gpo_blink: assert property (
    !r.setup[CFG_IRQEN] && r.setup[CFG_BLINK] && r.setup[CFG_FLIP] |=> ninthOe == !$past(r.setup[CFG_LVL1]))
    else $error("general output phase one level wrong");
  a_local_int: assert property (
    !r.setup[CFG_GLOBAL] |=> portIntensity[3] == $past(r.intens[1][7:4]))
    else $error("per-port intensity not applied");
  a_ninth_int: assert property (
    1'b1 |=> ninthIntensity == $past(r.master[3:0]))
    else $error("ninth pin intensity not from master register");

  c_cmd_then_write: cover property (rx.valid && rx.first ##[1:40] rx.valid && !rx.first);
  c_read_input: cover property (txReq.load && r.ptr == ADR_INPUT);
  c_irq_raise: cover property (r.setup[CFG_IRQEN] && changed ##1 ninthOe);
  c_ptr_wrap: cover property (txReq.next && r.ptr == ADR_INT3);
  c_gpo_blink: cover property (!r.setup[CFG_IRQEN] && phaseOne);
endmodule

// [testbench/ioe_i2c_master.sv]
// Two-wire bus master model that frames register writes and reads
`timescale 1ns/1ps
module ioe_i2c_master (
  output logic sclLow, // Master pulls the clock low
  output logic sdaLow, // Master pulls the data line low
  input wire logic sdaWire, // Resolved data line
  input wire logic [6:0] addr // Slave address to call
);
  int halfNs = 200; // Clock half period, raised to act as a slow master
  int nacks = 0; // Bytes that went unacknowledged

  // Both lines released at start, so the pull-ups hold the bus idle
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end

  // One clock pulse; data moves only mid-way through the low phase
  task automatic pulse(input logic b, output logic s);
    #(halfNs / 2) sdaLow = !b;
    #(halfNs / 2) sclLow = 1'b0;
    #(halfNs / 2) s = sdaWire;
    #(halfNs / 2) sclLow = 1'b1;
  endtask

  // Start or repeated start; the clock then stays low
  task automatic start();
    #(halfNs / 2) sdaLow = 1'b0;
    #(halfNs / 2) sclLow = 1'b0;
    #(halfNs / 2) sdaLow = 1'b1;
    #(halfNs / 2) sclLow = 1'b1;
  endtask

  // Stop leaves the clock standing high until the next frame
  task automatic stop();
    #(halfNs / 2) sdaLow = 1'b1;
    #(halfNs / 2) sclLow = 1'b0;
    #(halfNs / 2) sdaLow = 1'b0;
    #(halfNs / 2);
  endtask

  // Byte out, most significant bit first, then the slave's acknowledge
  task automatic sendByte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(b[i], s);
    end
    pulse(1'b1, s);
    if (s !== 1'b0) nacks++;
  endtask

  // Byte in; the master acknowledges all but the last
  task automatic recvByte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(1'b1, s);
      b[i] = s;
    end
    pulse(!ack, s);
  endtask

  // Whole frame: write n bytes at cmd, or read n bytes at the stored pointer
  task automatic frame(input logic isRd, input logic setPtr, input logic [7:0] cmd, input int n,
                       inout logic [7:0] d [6]);
    start();
    if (!isRd || setPtr) begin
      sendByte({addr, 1'b0});
      sendByte(cmd);
      if (isRd) start();
    end
    if (isRd) sendByte({addr, 1'b1});
    for (int i = 0; i < n; i++) begin
      if (isRd) recvByte(i < n - 1, d[i]);
      else sendByte(d[i]);
    end
    stop();
  endtask
endmodule

// [testbench/test_ioe_port_core.sv]
// Self-checking bench of the port expander core driven over the two-wire bus
`timescale 1ns/1ps
module test_ioe_port_core;
  import ioe_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [6:0] devAddr;
  logic [7:0] ext; // External drive of the port pins, one = released
  logic sclLow, sdaLow, sdaOut, sdaOe, ninthOut, ninthOe, sdaWire;
  logic [7:0] portOut, portOe, pins, ptr, snap, cmd, v;
  logic [7:0][3:0] portIntensity;
  logic [3:0] ninthIntensity, masterIntensity;
  logic [7:0] d [6];
  logic [7:0] sh [32]; // Shadow registers, indexed by the low five address bits
  logic [7:0] adrs [10] = '{8'h00, 8'h01, 8'h03, 8'h09, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13};
  logic [7:0] gpo [5] = '{8'h00, 8'h10, 8'h23, 8'h13, 8'h11};
  int err_total = 0;
  int checks = 0;
  int seed = 32'h180d;

  // Open-drain wires resolve against pull-ups
  assign pins = ext & ~portOe;
  assign sdaWire = !(sdaOe | sdaLow);

  ioe_port_core ioe_port_core_inst (.sys_clk(sys_clk), .arst_n(arst_n), .sclIn(!sclLow), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .devAddr(devAddr), .portIn(pins), .portOut(portOut), .portOe(portOe),
    .ninthOut(ninthOut), .ninthOe(ninthOe), .portIntensity(portIntensity), .ninthIntensity(ninthIntensity),
    .masterIntensity(masterIntensity));
  ioe_i2c_master ioe_i2c_master_inst (.sclLow(sclLow), .sdaLow(sdaLow), .sdaWire(sdaWire), .addr(devAddr));

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  // Expectation helpers built from the shadow registers
  function automatic logic mapped(input logic [7:0] a);
    return (a inside {8'h00, 8'h01, 8'h03, 8'h09, 8'h0E, 8'h0F}) || a[7:2] == 6'h04;
  endfunction
  function automatic logic [7:0] nxt(input logic [7:0] a);
    return (a[7:2] == 6'h04) ? {a[7:2], a[1:0] + 2'h1} : a;
  endfunction
  function automatic logic [7:0] sel();
    return (sh[15][0] & sh[15][1]) ? sh[9] : sh[1];
  endfunction
  function automatic logic [7:0] pinsExp();
    return ext & (sh[3] | sel());
  endfunction
  function automatic logic chgExp();
    return |((pinsExp() ^ snap) & sh[3]);
  endfunction
  function automatic logic [7:0] expv(input logic [7:0] a);
    if (a == 8'h00) return pinsExp();
    if (a == 8'h0F) return {chgExp(), 1'b0, sh[15][5:0]};
    return mapped(a) ? sh[a[4:0]] : 8'h00;
  endfunction

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Port side outputs against the shadow state
  task automatic checkOuts();
    logic [7:0] s;
    s = sh[15];
    check("portOe", portOe, ~sh[3] & ~sel());
    check("ninthOe", ninthOe, s[3] ? chgExp() : !((s[0] & s[1]) ? s[5] : s[4]));
    check("ninthInt", ninthIntensity, sh[14][3:0]);
    check("masterInt", masterIntensity, sh[14][7:4]);
    for (int i = 0; i < 8; i++) begin
      check("portInt", portIntensity[i], s[2] ? sh[14][3:0] : sh[16 + i / 2][4 * (i % 2) +: 4]);
    end
    check("nacks", 8'(ioe_i2c_master_inst.nacks), 8'h00);
    check("portOut", portOut, 8'h00);
    check("pinDrive", {sdaOut, ninthOut}, 2'b00);
  endtask

  // Write frame; a setup write snapshots the pins as they were before it
  task automatic wr(input logic [7:0] c, input int n);
    ioe_i2c_master_inst.frame(1'b0, 1'b1, c, n, d);
    ptr = c;
    for (int i = 0; i < n; i++) begin
      if (ptr == 8'h0F) snap = pinsExp();
      if (mapped(ptr) && ptr != 8'h00) sh[ptr[4:0]] = (ptr == 8'h0F) ? (d[i] & 8'h3F) : d[i];
      ptr = nxt(ptr);
    end
    @(posedge sys_clk);
    #5;
    checkOuts();
  endtask

  // Read frame with repeated start, or at the stored pointer alone
  task automatic rd(input logic setPtr, input logic [7:0] c, input int n);
    ioe_i2c_master_inst.frame(1'b1, setPtr, c, n, d);
    if (setPtr) ptr = c;
    for (int i = 0; i < n; i++) begin
      if (ptr == 8'h00) snap = pinsExp();
      check("readData", d[i], expv(ptr));
      ptr = nxt(ptr);
    end
    @(posedge sys_clk);
    #5;
    checkOuts();
  endtask

  // Pin changes reach the ninth pin only through synchronisers, so poll a bounded time
  task automatic waitNinth(input logic exp);
    int i;
    for (i = 0; i < 20 && ninthOe !== exp; i++) begin
      @(posedge sys_clk);
      #5;
    end
    check("ninthWait", ninthOe, exp);
  endtask

  task automatic doReset();
    arst_n = 1'b0;
    foreach (sh[i]) sh[i] = 8'h00;
    sh[1] = 8'hFF;
    sh[3] = 8'hFF;
    sh[9] = 8'hFF;
    sh[14] = 8'h0F;
    sh[15] = 8'h0C;
    for (int i = 16; i < 20; i++) sh[i] = 8'hFF;
    ext = 8'($random(seed));
    repeat (3) @(posedge sys_clk);
    #5;
    arst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      #5;
      check("ninthInit", ninthOe, 1'b0);
    end
    snap = pinsExp();
    checkOuts();
  endtask

  initial begin
    v = 8'($random(seed));
    devAddr = v[6:0];
    doReset();
    foreach (adrs[i]) rd(1'b1, adrs[i], 1);
    // Random traffic at both clock speeds, unmapped commands among it
    for (int k = 0; k < 16; k++) begin
      v = 8'($random(seed));
      ioe_i2c_master_inst.halfNs = k[0] ? 400 : 200;
      cmd = (v[7:4] == 4'h0) ? v : adrs[v[3:0] % 10];
      foreach (d[i]) d[i] = 8'($random(seed));
      wr(cmd, v[1:0] + 1);
      rd(1'b1, cmd, 3);
    end
    foreach (d[i]) d[i] = 8'($random(seed));
    wr(8'h12, 4);
    rd(1'b1, 8'h10, 6);
    wr(8'h09, 0);
    rd(1'b0, 8'h00, 2);
    wr(8'h00, 1);
    rd(1'b1, 8'h00, 1);
    wr(8'h0B, 2);
    rd(1'b1, 8'h2A, 2);
    // Change detection with every port an input
    d[0] = 8'hFF;
    wr(8'h03, 1);
    d[0] = 8'h08;
    wr(8'h0F, 1);
    ext[2] = !ext[2];
    waitNinth(1'b1);
    rd(1'b1, 8'h0F, 1);
    ext[2] = !ext[2];
    waitNinth(1'b0);
    ext[5] = !ext[5];
    waitNinth(1'b1);
    rd(1'b1, 8'h00, 1);
    // Ninth pin as a general output, and blink phases on output ports
    d[0] = 8'h00;
    wr(8'h03, 1);
    d[0] = 8'($random(seed));
    wr(8'h01, 1);
    d[0] = ~d[0];
    wr(8'h09, 1);
    foreach (gpo[i]) begin
      d[0] = gpo[i];
      wr(8'h0F, 1);
    end
    doReset();
    rd(1'b1, 8'h0F, 1);
    finish_test();
  end

  // Cuts a hang short
  initial begin
    repeat (100000) @(posedge sys_clk);
    err_total++;
    finish_test();
  end
endmodule
